/* logic/psa_pkg.sv */
// constants, types and reset values for the program space access unit
// How it works
// RQ1 - source and destination modes chosen separately
// RQ2 - one offset register value shared by both
// RQ3 - literal offset and 8/16-bit immediates
// RQ4 - signed branch literal, 14-bit hold field
// RQ5 - 24-bit program words, 16-bit data, aligned
// RQ6 - table address is page above effective address
// RQ7 - page top bit picks configuration space
// RQ8 - window address is visibility page plus 15 bits
// RQ9 - window drops bit 15, page bit 0 replaces
// RQ10 - window address bit 23 always zero
// RQ11 - window is read-only, low word only
// RQ12 - fetch and window addresses have bit 0 zero
// RQ13 - table access unaligned, may reach configuration
// RQ14 - program counter steps two per word
// RQ15 - only table-high reaches the upper byte
// RQ16 - table-low read word or selected byte
// RQ17 - table-high word read zeroes phantom byte
// RQ18 - table-high byte read of phantom gives zero
// RQ19 - each table access is byte or word
// RQ20 - window needs top EA bit and enable
// RQ21 - window read costs one extra cycle
// RQ22 - address format follows the core's access kind
package psa_pkg;

  localparam int PADDR_W = 24;
  localparam int DATA_W = 16;

  // register byte addresses on the plain register port
  localparam logic [3:0] REG_TABLE_PAGE = 4'h0;
  localparam logic [3:0] REG_VIS_PAGE = 4'h4;
  localparam logic [3:0] REG_CORE_CTRL = 4'h8;
  localparam logic [3:0] REG_STATUS = 4'hc;

  // field positions
  localparam int CTRL_VIS_EN_BIT = 2;
  localparam int STAT_WERR_BIT = 0;
  localparam int STAT_BUSY_BIT = 1;
  localparam int PAGE_CFG_BIT = 7;

  // values after reset
  localparam logic [7:0] RST_TABLE_PAGE = 8'h00;
  localparam logic [7:0] RST_VIS_PAGE = 8'h00;
  localparam logic RST_VIS_EN = 1'b0;

  // program counter step per program word
  localparam logic [23:0] PC_STEP = 24'h000002;

  // flash byte lanes: bit 2 upper byte, bit 1 middle, bit 0 low
  localparam logic [2:0] BE_NONE = 3'h0;
  localparam logic [2:0] BE_LOW_BYTE = 3'h1;
  localparam logic [2:0] BE_MID_BYTE = 3'h2;
  localparam logic [2:0] BE_LOW_WORD = 3'h3;
  localparam logic [2:0] BE_HIGH = 3'h4;

  // access kind issued by the core each cycle
  typedef enum logic [1:0] {
    ACC_FETCH = 2'h0,
    ACC_TABLE = 2'h1,
    ACC_DATA = 2'h2,
    ACC_NONE = 2'h3
  } psa_acc_t;

  // move operand addressing modes
  typedef enum logic [2:0] {
    EA_DIRECT = 3'h0,
    EA_INDIRECT = 3'h1,
    EA_POST_MOD = 3'h2,
    EA_PRE_MOD = 3'h3,
    EA_INDEXED = 3'h4,
    EA_LIT_OFFSET = 3'h5,
    EA_IMM8 = 3'h6,
    EA_IMM16 = 3'h7
  } psa_ea_mode_t;

  // operand kind reported with each effective address
  localparam logic [1:0] OPK_MEMORY = 2'h0;
  localparam logic [1:0] OPK_REGISTER = 2'h1;
  localparam logic [1:0] OPK_IMMEDIATE = 2'h2;

  typedef enum logic [3:0] {
    ST_IDLE = 4'h1,
    ST_RD1 = 4'h2,
    ST_RD2 = 4'h4,
    ST_CAP = 4'h8
  } psa_fsm_t;

  typedef struct packed {
    psa_fsm_t st;
    psa_acc_t kind;
    logic [7:0] tblPage;
    logic [7:0] visPage;
    logic visEn;
    logic wrErr;
    logic busy;
    logic [15:0] rdData;
    logic [23:0] fAddr;
    logic fRd;
    logic fWr;
    logic [2:0] fBe;
    logic [23:0] fWd;
    logic high;
    logic byteMode;
    logic bsel;
    logic respValid;
    logic [15:0] respData;
    logic [23:0] respWord;
    logic [23:0] nextPc;
    logic [15:0] srcEa;
    logic [15:0] dstEa;
    logic [1:0] srcKind;
    logic [1:0] dstKind;
    logic [23:0] brTarget;
    logic [13:0] holdCnt;
  } psa_regs_t;

  localparam psa_regs_t RST_REGS = '{
    st: ST_IDLE,
    kind: ACC_NONE,
    tblPage: RST_TABLE_PAGE,
    visPage: RST_VIS_PAGE,
    visEn: RST_VIS_EN,
    default: '0
  };

endpackage

/* logic/psa_program_space_access.sv */
// address generation and data path from the core into program space
`timescale 1ns/1ps
module psa_program_space_access (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [3:0] regAddr,
  input wire logic [15:0] regWrData,
  input wire logic regWr,
  input wire logic regRd,
  output logic [15:0] regRdData,
  input wire logic reqValid,
  input wire psa_pkg::psa_acc_t reqKind,
  input wire logic reqWrite,
  input wire logic reqHigh,
  input wire logic reqByte,
  input wire logic [15:0] reqEa,
  input wire logic [23:0] reqPc,
  input wire logic [15:0] reqWrData,
  output logic reqBusy,
  output logic [23:0] flashAddr,
  output logic flashRd,
  output logic flashWr,
  output logic [2:0] flashBe,
  output logic [23:0] flashWrData,
  input wire logic [23:0] flashRdData,
  output logic respValid,
  output logic [15:0] respData,
  output logic [23:0] respWord,
  output logic [23:0] nextPc,
  input wire psa_pkg::psa_ea_mode_t srcMode,
  input wire psa_pkg::psa_ea_mode_t dstMode,
  input wire logic [15:0] srcWn,
  input wire logic [15:0] dstWn,
  input wire logic [15:0] offsetRegValue,
  input wire logic [15:0] srcLit,
  input wire logic [15:0] dstLit,
  output logic [15:0] srcEa,
  output logic [15:0] dstEa,
  output logic [1:0] srcKind,
  output logic [1:0] dstKind,
  input wire logic [15:0] branchLit,
  input wire logic [13:0] holdLit,
  output logic [23:0] branchTarget,
  output logic [13:0] holdCount
);

  psa_pkg::psa_regs_t q;
  psa_pkg::psa_regs_t n;

  // effective address of one move operand
  function automatic logic [15:0] eaOf(
    input psa_pkg::psa_ea_mode_t mode,
    input logic [15:0] wn,
    input logic [15:0] wb,
    input logic [15:0] lit
  );
    logic [15:0] r;
    r = wn;
    unique case (mode)
      psa_pkg::EA_DIRECT: r = wn;
      psa_pkg::EA_INDIRECT: r = wn;
      psa_pkg::EA_POST_MOD: r = wn;
      psa_pkg::EA_PRE_MOD: r = wn + lit;
      psa_pkg::EA_INDEXED: r = wn + wb; // [RQ2]
      psa_pkg::EA_LIT_OFFSET: r = wn + lit; // [RQ3]
      psa_pkg::EA_IMM8: r = {8'h00, lit[7:0]}; // [RQ3]
      psa_pkg::EA_IMM16: r = lit; // [RQ3]
    endcase
    return r;
  endfunction

  // what the operand value is: memory address, register or literal
  function automatic logic [1:0] kindOf(
    input psa_pkg::psa_ea_mode_t mode
  );
    logic [1:0] k;
    k = psa_pkg::OPK_MEMORY;
    if (mode == psa_pkg::EA_DIRECT) begin
      k = psa_pkg::OPK_REGISTER;
    end else if (mode == psa_pkg::EA_IMM8 || mode == psa_pkg::EA_IMM16) begin
      k = psa_pkg::OPK_IMMEDIATE;
    end
    return k;
  endfunction

  // lane selection and phantom-byte zeroing of a table read
  function automatic logic [15:0] fmtTable(
    input logic [23:0] w,
    input logic high,
    input logic byteMode,
    input logic bsel
  );
    logic [15:0] r;
    r = 16'h0000;
    if (!high) begin
      if (!byteMode) begin
        r = w[15:0]; // [RQ16]
      end else begin
        r = {8'h00, bsel ? w[15:8] : w[7:0]}; // [RQ16]
      end
    end else begin
      if (!byteMode) begin
        r = {8'h00, w[23:16]}; // [RQ17]
      end else begin
        r = bsel ? 16'h0000 : {8'h00, w[23:16]}; // [RQ18]
      end
    end
    return r;
  endfunction

  // register read mux, unmapped offsets read zero
  function automatic logic [15:0] regRead(
    input psa_pkg::psa_regs_t s,
    input logic [3:0] a
  );
    logic [15:0] r;
    r = 16'h0000;
    unique case (a)
      psa_pkg::REG_TABLE_PAGE: r = {8'h00, s.tblPage};
      psa_pkg::REG_VIS_PAGE: r = {8'h00, s.visPage};
      psa_pkg::REG_CORE_CTRL: r[psa_pkg::CTRL_VIS_EN_BIT] = s.visEn;
      psa_pkg::REG_STATUS: begin
        r[psa_pkg::STAT_WERR_BIT] = s.wrErr;
        r[psa_pkg::STAT_BUSY_BIT] = s.busy;
      end
      default: r = 16'h0000;
    endcase
    return r;
  endfunction

  // next state of the whole unit
  always_comb begin
    n = q;
    n.rdData = 16'h0000;
    n.fRd = 1'b0;
    n.fWr = 1'b0;
    n.respValid = 1'b0;

    // software side; a page written in the same cycle as a request
    // takes effect for the next request only
    if (regWr) begin
      unique case (regAddr)
        psa_pkg::REG_TABLE_PAGE: n.tblPage = regWrData[7:0];
        psa_pkg::REG_VIS_PAGE: n.visPage = regWrData[7:0];
        psa_pkg::REG_CORE_CTRL:
          n.visEn = regWrData[psa_pkg::CTRL_VIS_EN_BIT];
        psa_pkg::REG_STATUS:
          if (regWrData[psa_pkg::STAT_WERR_BIT]) n.wrErr = 1'b0;
        default: n.rdData = 16'h0000;
      endcase
    end
    if (regRd) begin
      n.rdData = regRead(q, regAddr);
    end

    // move operand addresses, modes chosen per operand
    n.srcEa = eaOf(srcMode, srcWn, offsetRegValue, srcLit); // [RQ1]
    n.dstEa = eaOf(dstMode, dstWn, offsetRegValue, dstLit); // [RQ1]
    n.srcKind = kindOf(srcMode); // [RQ1]
    n.dstKind = kindOf(dstMode); // [RQ1]

    // branch literal counts in words, so the literal is doubled
    n.brTarget = reqPc + psa_pkg::PC_STEP
      + {{7{branchLit[15]}}, branchLit, 1'b0}; // [RQ4]
    n.holdCnt = holdLit; // [RQ4]

    // access sequencer; one access in flight keeps the window
    // out of the way while a table access runs
    unique case (q.st)
      psa_pkg::ST_IDLE: begin
        if (reqValid) begin
          n.kind = reqKind;
          n.high = reqHigh;
          n.byteMode = reqByte; // [RQ19]
          n.bsel = reqEa[0];
          unique case (reqKind) // [RQ22]
            psa_pkg::ACC_FETCH: begin
              n.fAddr = {1'b0, reqPc[22:1], 1'b0}; // [RQ12]
              n.nextPc = reqPc + psa_pkg::PC_STEP; // [RQ14]
              n.fRd = 1'b1;
              n.st = psa_pkg::ST_RD1;
            end
            psa_pkg::ACC_TABLE: begin
              // full address, no alignment; bit 7 of the page
              // lands on bit 23 and selects configuration space
              n.fAddr = {q.tblPage, reqEa}; // [RQ6] [RQ7] [RQ13]
              if (reqWrite) begin
                n.fWd = 24'h000000;
                n.fBe = psa_pkg::BE_NONE;
                if (!reqHigh && !reqByte) begin
                  n.fBe = psa_pkg::BE_LOW_WORD; // [RQ15]
                  n.fWd = {8'h00, reqWrData};
                end else if (!reqHigh) begin
                  n.fBe = reqEa[0] ? psa_pkg::BE_MID_BYTE
                                   : psa_pkg::BE_LOW_BYTE; // [RQ19]
                  n.fWd = reqEa[0] ? {8'h00, reqWrData[7:0], 8'h00}
                                   : {16'h0000, reqWrData[7:0]};
                end else if (!reqByte || !reqEa[0]) begin
                  n.fBe = psa_pkg::BE_HIGH; // [RQ15]
                  n.fWd = {reqWrData[7:0], 16'h0000};
                end
                // the phantom byte has no storage: nothing is written
                n.fWr = (n.fBe != psa_pkg::BE_NONE);
                n.respValid = 1'b1;
                n.respData = 16'h0000;
              end else begin
                n.fRd = 1'b1;
                n.st = psa_pkg::ST_RD1;
              end
            end
            psa_pkg::ACC_DATA: begin
              if (reqEa[15] && q.visEn) begin // [RQ20]
                if (reqWrite) begin
                  n.wrErr = 1'b1; // [RQ11]
                end else begin
                  // bit 15 of the EA is dropped, page bit 0 takes it
                  n.fAddr = {1'b0, q.visPage, reqEa[14:1],
                             1'b0}; // [RQ8] [RQ9] [RQ10] [RQ12]
                  n.fRd = 1'b1;
                  n.st = psa_pkg::ST_RD1;
                end
              end
            end
            psa_pkg::ACC_NONE: n.kind = psa_pkg::ACC_NONE;
          endcase
        end
      end
      psa_pkg::ST_RD1: begin
        if (q.kind == psa_pkg::ACC_DATA) begin
          n.fRd = 1'b1; // [RQ21]
          n.st = psa_pkg::ST_RD2;
        end else begin
          n.st = psa_pkg::ST_CAP;
        end
      end
      psa_pkg::ST_RD2: n.st = psa_pkg::ST_CAP; // [RQ21]
      psa_pkg::ST_CAP: begin
        n.respValid = 1'b1;
        n.respWord = flashRdData; // [RQ5]
        if (q.kind == psa_pkg::ACC_TABLE) begin
          n.respData = fmtTable(flashRdData, q.high, q.byteMode,
                                q.bsel);
        end else begin
          n.respData = flashRdData[15:0]; // [RQ11]
        end
        n.st = psa_pkg::ST_IDLE;
      end
      default: n.st = psa_pkg::ST_IDLE;
    endcase
    n.busy = (n.st != psa_pkg::ST_IDLE);
  end

  // single state register, synchronous reset
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      q <= psa_pkg::RST_REGS;
    end else begin
      q <= n;
    end
  end

  // every output is a field of the state register
  assign regRdData = q.rdData;
  assign reqBusy = q.busy;
  assign flashAddr = q.fAddr;
  assign flashRd = q.fRd;
  assign flashWr = q.fWr;
  assign flashBe = q.fBe;
  assign flashWrData = q.fWd;
  assign respValid = q.respValid;
  assign respData = q.respData;
  assign respWord = q.respWord;
  assign nextPc = q.nextPc;
  assign srcEa = q.srcEa;
  assign dstEa = q.dstEa;
  assign srcKind = q.srcKind;
  assign dstKind = q.dstKind;
  assign branchTarget = q.brTarget;
  assign holdCount = q.holdCnt;

endmodule

/* test/psa_props.sv */
// concurrent checks on the program space access unit ports
`timescale 1ns/1ps
module psa_props (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic reqValid,
  input wire psa_pkg::psa_acc_t reqKind,
  input wire logic reqWrite,
  input wire logic reqHigh,
  input wire logic reqByte,
  input wire logic [15:0] reqEa,
  input wire logic [23:0] reqPc,
  input wire logic reqBusy,
  input wire logic [23:0] flashAddr,
  input wire logic flashRd,
  input wire logic flashWr,
  input wire logic [2:0] flashBe,
  input wire logic respValid,
  input wire logic [15:0] respData
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  // accepted request kinds, busy gates every one of them
  wire logic acc = reqValid && !reqBusy;
  wire logic tblRd = acc && reqKind == psa_pkg::ACC_TABLE && !reqWrite;
  wire logic tblWr = acc && reqKind == psa_pkg::ACC_TABLE && reqWrite;
  wire logic winRd = acc && reqKind == psa_pkg::ACC_DATA && !reqWrite
    && reqEa[15];
  rd_lat_a: assert property (tblRd |=> flashRd ##2 respValid)
    else $error("table read timing wrong");
  tbl_addr_a: assert property (tblRd |=>
    flashAddr[15:0] == $past(reqEa)) else $error("table address wrong");
  win_addr_a: assert property (winRd |=> !flashRd ||
    (!flashAddr[23] && flashAddr[14:0] == {$past(reqEa[14:1]), 1'b0}))
    else $error("window address wrong");
  win_extra_a: assert property (winRd ##1 flashRd |=>
    flashRd ##2 respValid) else $error("window read timing wrong");
  fetch_addr_a: assert property (
    acc && reqKind == psa_pkg::ACC_FETCH |=>
    flashRd && flashAddr == {1'b0, $past(reqPc[22:1]), 1'b0})
    else $error("fetch address wrong");
  win_ro_a: assert property (acc && reqKind == psa_pkg::ACC_DATA &&
    reqWrite |=> !flashWr && !flashRd && !respValid)
    else $error("window write reached flash");
  hi_lane_a: assert property (tblWr && reqHigh && !reqByte |=>
    flashWr && flashBe == psa_pkg::BE_HIGH) else $error("high lane wrong");
  phantom_a: assert property (tblRd && reqHigh && reqByte &&
    reqEa[0] |=> ##2 respData == 16'h0000) else $error("phantom not 0");
  cover property (tblRd ##3 respValid);
  cover property (winRd ##4 respValid);
  cover property (tblWr ##1 flashWr);
endmodule
bind psa_program_space_access psa_props i_props (.clk(clk), .rst_n(rst_n),
  .reqValid(reqValid), .reqKind(reqKind), .reqWrite(reqWrite),
  .reqHigh(reqHigh), .reqByte(reqByte), .reqEa(reqEa), .reqPc(reqPc),
  .reqBusy(reqBusy), .flashAddr(flashAddr), .flashRd(flashRd),
  .flashWr(flashWr), .flashBe(flashBe), .respValid(respValid),
  .respData(respData));

/* test/psa_flash_model.sv */
// program flash array model: answers one cycle after each read pulse
`timescale 1ns/1ps
module psa_flash_model (
  input wire logic clk,
  input wire logic [23:0] flashAddr,
  input wire logic flashRd,
  output logic [23:0] flashRdData
);
  // content is a fixed pattern of the address, 24 bits per word
  function automatic logic [23:0] pw(input logic [23:0] a);
    return {a[7:0] ^ 8'ha5, a[15:0] ^ 16'h3c3c};
  endfunction
  // outside a read the bus flips every cycle so data one cycle stale never matches
  always @(posedge clk) begin
    flashRdData <= flashRd ? pw(flashAddr) : ~flashRdData;
  end
  initial flashRdData = 24'h0;
endmodule

/* test/program_space_access_unit_tb_top.sv */
// self-checking bench for the program space access unit
`timescale 1ns/1ps
module program_space_access_unit_tb_top;
  logic clk, rst_n, regWr, regRd, reqValid, reqWrite, reqHigh, reqByte;
  logic [3:0] regAddr;
  logic [15:0] regWrData, regRdData, reqEa, reqWrData, srcWn, dstWn;
  logic [15:0] offsetRegValue, srcLit, dstLit, srcEa, dstEa, respData;
  logic [15:0] branchLit, r;
  logic [23:0] reqPc, flashAddr, flashWrData, flashRdData, respWord;
  logic [23:0] nextPc, branchTarget, fa, fwd, w, m;
  logic [2:0] flashBe, fbe, eb;
  logic [1:0] srcKind, dstKind;
  logic [13:0] holdLit, holdCount;
  logic reqBusy, flashRd, flashWr, respValid, bsy;
  psa_pkg::psa_acc_t reqKind;
  psa_pkg::psa_ea_mode_t srcMode, dstMode;
  int n_fail, tests_run, n, nwr;
  psa_program_space_access i_dut (.clk(clk), .rst_n(rst_n),
    .regAddr(regAddr), .regWrData(regWrData), .regWr(regWr),
    .regRd(regRd), .regRdData(regRdData), .reqValid(reqValid),
    .reqKind(reqKind), .reqWrite(reqWrite), .reqHigh(reqHigh),
    .reqByte(reqByte), .reqEa(reqEa), .reqPc(reqPc),
    .reqWrData(reqWrData), .reqBusy(reqBusy), .flashAddr(flashAddr),
    .flashRd(flashRd), .flashWr(flashWr), .flashBe(flashBe),
    .flashWrData(flashWrData), .flashRdData(flashRdData),
    .respValid(respValid), .respData(respData), .respWord(respWord),
    .nextPc(nextPc), .srcMode(srcMode), .dstMode(dstMode),
    .srcWn(srcWn), .dstWn(dstWn), .offsetRegValue(offsetRegValue),
    .srcLit(srcLit), .dstLit(dstLit), .srcEa(srcEa), .dstEa(dstEa),
    .srcKind(srcKind), .dstKind(dstKind), .branchLit(branchLit),
    .holdLit(holdLit), .branchTarget(branchTarget),
    .holdCount(holdCount));
  psa_flash_model i_flash (.clk(clk), .flashAddr(flashAddr),
    .flashRd(flashRd), .flashRdData(flashRdData));
  task chk(input logic [23:0] s, input logic [23:0] e);
    tests_run++;
    if (s !== e) begin
      n_fail++;
      $display("Error %0t: got %h expected %h", $time, s, e);
    end
  endtask
  task wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk);
    regAddr <= a;
    regWrData <= d;
    regWr <= 1'b1;
    @(posedge clk);
    regWr <= 1'b0;
  endtask
  task rd(input logic [3:0] a, input logic [15:0] e);
    @(posedge clk);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge clk);
    regRd <= 1'b0;
    #1;
    chk({8'h00, regRdData}, {8'h00, e});
  endtask
  // one core access; n is the cycle of the answer, 6 when none came
  task op(input psa_pkg::psa_acc_t k, input logic wrt, hi, by,
    input logic [15:0] ea);
    @(posedge clk);
    reqValid <= 1'b1;
    reqKind <= k;
    reqWrite <= wrt;
    reqHigh <= hi;
    reqByte <= by;
    reqEa <= ea;
    @(posedge clk);
    reqValid <= 1'b0;
    n = 0;
    nwr = 0;
    repeat (6) begin
      #1;
      n++;
      // busy seen in the first cycle after the request was taken
      if (n == 1) bsy = reqBusy;
      if (flashRd === 1'b1) fa = flashAddr;
      if (flashWr === 1'b1) begin
        nwr++;
        fbe = flashBe;
        fwd = flashWrData;
      end
      if (respValid === 1'b1) break;
      @(posedge clk);
    end
  endtask
  task t_regs;
    rd(4'h0, 16'h0000);
    rd(4'h4, 16'h0000);
    rd(4'h8, 16'h0000);
    wr(4'h0, 16'hff81);
    rd(4'h0, 16'h0081);
    rd(4'h2, 16'h0000);
    $display("t_regs done");
  endtask
  // every lane and byte select of table reads in configuration space
  task t_table_rd;
    for (int i = 0; i < 8; i++) begin
      op(psa_pkg::ACC_TABLE, 1'b0, i[2], i[1], 16'h1234 | 16'(i[0]));
      w = i_flash.pw({8'h81, reqEa});
      chk(fa, {8'h81, reqEa});
      chk(24'(n), 24'd3);
      if (!i[2]) r = i[1] ? {8'h0, i[0] ? w[15:8] : w[7:0]} : w[15:0];
      else r = (i[1] && i[0]) ? 16'h0 : {8'h0, w[23:16]};
      chk({8'h00, respData}, {8'h00, r});
      chk({23'h0, bsy}, 24'h000001);
    end
    $display("t_table_rd done");
  endtask
  task t_table_wr;
    reqWrData <= 16'hbeef;
    for (int i = 0; i < 8; i++) begin
      op(psa_pkg::ACC_TABLE, 1'b1, i[2], i[1], 16'h0040 | 16'(i[0]));
      if (i[2]) eb = (i[1] && i[0]) ? 3'h0 : 3'h4;
      else eb = !i[1] ? 3'h3 : (i[0] ? 3'h2 : 3'h1);
      chk(24'(n), 24'd1);
      chk({23'h0, bsy}, 24'h000000);
      chk(24'(nwr), 24'(eb != 3'h0));
      m = {{8{eb[2]}}, {8{eb[1]}}, {8{eb[0]}}};
      if (eb != 3'h0) chk({21'h0, fbe}, {21'h0, eb});
      if (eb != 3'h0) chk(fwd & m,
        {8'hef, i[1] ? 16'hefef : 16'hbeef} & m);
    end
    $display("t_table_wr done");
  endtask
  task t_window;
    wr(4'h4, 16'h0033);
    wr(4'h8, 16'h0004);
    op(psa_pkg::ACC_DATA, 1'b0, 1'b0, 1'b0, 16'h9abd);
    chk(fa, {1'b0, 8'h33, reqEa[14:1], 1'b0});
    chk(24'(n), 24'd4);
    chk({8'h00, respData}, i_flash.pw(fa) & 24'h00ffff);
    // window on but EA top bit clear: plain data access, no answer
    op(psa_pkg::ACC_DATA, 1'b0, 1'b0, 1'b0, 16'h1abc);
    chk(24'(n), 24'd6);
    op(psa_pkg::ACC_DATA, 1'b1, 1'b0, 1'b0, 16'h9abc);
    chk(24'(n + nwr), 24'd6);
    rd(4'hc, 16'h0001);
    wr(4'hc, 16'h0001);
    rd(4'hc, 16'h0000);
    wr(4'h8, 16'h0000);
    op(psa_pkg::ACC_DATA, 1'b0, 1'b0, 1'b0, 16'h9abc);
    chk(24'(n), 24'd6);
    $display("t_window done");
  endtask
  // operand modes swept in opposite order on the two operands
  task t_move;
    for (int i = 0; i < 8; i++) begin
      srcMode <= psa_pkg::psa_ea_mode_t'(i[2:0]);
      dstMode <= psa_pkg::psa_ea_mode_t'(3'(7 - i));
      repeat (2) @(posedge clk);
      #1;
      chk({6'h0, srcKind, srcEa},
        ev(i[2:0], 16'h1000, 16'h0f83));
      chk({6'h0, dstKind, dstEa}, ev(3'(7 - i), 16'h2000, 16'h0142));
    end
    op(psa_pkg::ACC_FETCH, 1'b0, 1'b0, 1'b0, 16'h0);
    chk(fa, 24'h001234);
    chk(24'(n), 24'd3);
    chk(respWord, i_flash.pw(fa));
    chk(nextPc, 24'h801237);
    chk(branchTarget, 24'h801233);
    chk({10'h000, holdCount}, 24'h003abc);
    $display("t_move done");
  endtask
  function automatic logic [23:0] ev(input logic [2:0] md,
    input logic [15:0] wn, input logic [15:0] l);
    case (md)
      3'h0: return {6'h0, 2'h1, wn};
      3'h3, 3'h5: return {6'h0, 2'h0, wn + l};
      3'h4: return {6'h0, 2'h0, wn + 16'h0010};
      3'h6: return {6'h0, 2'h2, 8'h0, l[7:0]};
      3'h7: return {6'h0, 2'h2, l};
      default: return {6'h0, 2'h0, wn};
    endcase
  endfunction
  task tally_and_finish;
    $display("checks %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // watchdog well beyond the roughly 150 cycles the tests need
  initial begin
    repeat (5000) @(posedge clk);
    n_fail++;
    tally_and_finish;
  end
  initial begin
    {rst_n, regWr, regRd, reqValid, reqWrite, reqHigh, reqByte} = '0;
    {regAddr, regWrData, reqEa, reqWrData} = '0;
    reqKind = psa_pkg::ACC_NONE;
    srcMode = psa_pkg::EA_DIRECT;
    dstMode = psa_pkg::EA_DIRECT;
    {srcWn, dstWn, offsetRegValue} = {16'h1000, 16'h2000, 16'h0010};
    {srcLit, dstLit, branchLit} = {16'h0f83, 16'h0142, 16'hfffe};
    reqPc = 24'h801235;
    holdLit = 14'h3abc;
    n_fail = 0;
    tests_run = 0;
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    t_regs;
    t_table_rd;
    t_table_wr;
    t_window;
    t_move;
    tally_and_finish;
  end
endmodule
